// ---- src/tsq_defines.svh ----
// constants for the four-channel trigger sequencer
`ifndef TSQ_DEFINES_SVH
`define TSQ_DEFINES_SVH

// source select codes
`define TSQ_SRC_BUS 4'h0
`define TSQ_SRC_ECL0 4'h1
`define TSQ_SRC_TTL0 4'h3
`define TSQ_SRC_AUX 4'hB
`define TSQ_SRC_LAST 4'hB
`define TSQ_SRC_W 4
`define TSQ_NUM_SRC 12

// reset values and limits of the counts
`define TSQ_COUNT_DEF 15'h0001
`define TSQ_COUNT_MIN 15'h0001

// configuration field select codes
`define TSQ_CFG_SRC 2'h0
`define TSQ_CFG_ECNT 2'h1
`define TSQ_CFG_TCNT 2'h2

// channel assumed when no selector is given
`define TSQ_DEF_CHAN 2'h0

`endif

// ---- src/tsq_pkg.sv ----
// types shared by the trigger sequencer files
package tsq_pkg;
    // gray coded along idle, armed, triggered
    typedef enum logic [1:0] {
        TSQ_IDLE = 2'b00,
        TSQ_ARMED = 2'b01,
        TSQ_TRIG = 2'b11
    } tsq_state_t;
endpackage

// ---- src/tsq_chan.sv ----
// one trigger channel: state machine, event counter and loop counter
`timescale 1ns/10ps
`include "tsq_defines.svh"
module tsq_chan #(
    parameter int CW = 15
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_idle_all,
    input wire logic i_arm_all,
    input wire logic i_rearm,
    input wire logic i_src_evt,
    input wire logic i_sim_evt,
    input wire logic i_force,
    input wire logic [CW-1:0] i_event_count_setting,
    input wire logic [CW-1:0] i_tcount,
    output logic [1:0] o_state,
    output logic o_action,
    output logic o_ignored
);
    tsq_pkg::tsq_state_t state_r;
    tsq_pkg::tsq_state_t state_nxt;
    logic [CW-1:0] ev_cnt_r;
    logic [CW-1:0] ev_cnt_inc;
    logic [CW-1:0] loop_cnt_r;
    logic evt;
    logic ev_done;

    // a simulated trigger counts exactly like a source transition
    assign evt = i_src_evt | i_sim_evt;
    assign ev_cnt_inc = ev_cnt_r + CW'(1);
    assign ev_done = (ev_cnt_inc >= i_event_count_setting);
    assign o_state = state_r;

    // next state
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            tsq_pkg::TSQ_IDLE: begin
                if (i_arm_all) begin
                    state_nxt = tsq_pkg::TSQ_ARMED;
                end
            end
            tsq_pkg::TSQ_ARMED: begin
                if (i_force || (evt && ev_done)) begin
                    state_nxt = tsq_pkg::TSQ_TRIG;
                end
            end
            tsq_pkg::TSQ_TRIG: begin
                if (i_rearm || (loop_cnt_r < i_tcount)) begin
                    state_nxt = tsq_pkg::TSQ_ARMED;
                end else begin
                    state_nxt = tsq_pkg::TSQ_IDLE;
                end
            end
            default: begin
                state_nxt = tsq_pkg::TSQ_IDLE;
            end
        endcase
        if (i_idle_all) begin
            state_nxt = tsq_pkg::TSQ_IDLE;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            state_r <= tsq_pkg::TSQ_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst || state_r != tsq_pkg::TSQ_ARMED) begin
            ev_cnt_r <= '0;
        end else if (evt && !ev_done) begin
            ev_cnt_r <= ev_cnt_inc;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_srst || state_r == tsq_pkg::TSQ_IDLE) begin
            loop_cnt_r <= '0;
        end else if (state_nxt == tsq_pkg::TSQ_TRIG && loop_cnt_r != '1) begin
            loop_cnt_r <= loop_cnt_r + CW'(1);
        end
    end

    // action strobe stands in the triggered cycle
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_action <= 1'b0;
        end else begin
            o_action <= (state_nxt == tsq_pkg::TSQ_TRIG);
        end
    end

    // force or simulate outside armed is dropped
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_ignored <= 1'b0;
        end else begin
            o_ignored <= (i_force | i_sim_evt) && (state_r != tsq_pkg::TSQ_ARMED);
        end
    end
endmodule

// ---- src/tsq_top.sv ----
// four-channel trigger sequencer with source selection and counts
`timescale 1ns/10ps
`include "tsq_defines.svh"
module tsq_top #(
    parameter int NCH = 4,
    parameter int CW = 15
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_cmd_reset,
    input wire logic i_cmd_abort,
    input wire logic i_cmd_arm,
    input wire logic i_continuous_rearm,
    input wire logic i_bus_trg_cmd,
    input wire logic i_bus_trg_ws,
    input wire logic [1:0] i_ecl_trg,
    input wire logic [7:0] i_ttl_trg,
    input wire logic i_aux_trg,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_chan_vld,
    input wire logic [1:0] i_cfg_chan,
    input wire logic [1:0] i_cfg_field,
    input wire logic [CW-1:0] i_cfg_data,
    input wire logic i_force_trg,
    input wire logic i_sim_trg,
    input wire logic i_trg_chan_vld,
    input wire logic [1:0] i_trg_chan,
    input wire logic [1:0] i_rd_chan,
    output logic [2*NCH-1:0] o_chan_state,
    output logic [NCH-1:0] o_action_strb,
    output logic [NCH-1:0] o_trg_ignored,
    output logic [`TSQ_SRC_W-1:0] o_rd_src,
    output logic [CW-1:0] o_rd_event_count_setting,
    output logic [CW-1:0] o_rd_tcount
);
    logic [`TSQ_SRC_W-1:0] src_r [NCH];
    logic [CW-1:0] event_count_setting_r [NCH];
    logic [CW-1:0] tcount_r [NCH];
    // history of the ten backplane lines, ECL in the low two bits
    logic [9:0] line_prev_r;
    logic aux_prev_r;
    logic [9:0] line_rise;
    logic aux_rise;
    logic bus_evt;
    logic [`TSQ_NUM_SRC-1:0] evt_vec;
    // one-hot channel picks for configuration and for force or simulate
    logic [NCH-1:0] cfg_sel;
    logic [NCH-1:0] trg_sel;
    logic idle_all;
    logic arm_all;
    logic cfg_src_ok;
    logic cfg_cnt_ok;

    // one-hot channel decode; an absent selector picks channel zero
    // configuration and force/simulate share this decode, so both fall
    // back to the same channel when the host leaves the selector out
    function automatic logic [NCH-1:0] chan_decode(input logic vld, input logic [1:0] chan);
        logic [1:0] idx;
        idx = vld ? chan : `TSQ_DEF_CHAN;
        chan_decode = '0;
        chan_decode[idx] = 1'b1;
    endfunction

    assign cfg_sel = chan_decode(i_cfg_chan_vld, i_cfg_chan);
    assign trg_sel = chan_decode(i_trg_chan_vld, i_trg_chan);

    // abort and the reset command win over an arm in the same cycle,
    // because each channel applies idle_all after its own next-state pick
    // reset command and abort idle every channel
    assign idle_all = i_cmd_reset | i_cmd_abort;

    // continuous re-arm also acts as a standing arm, so a channel that
    // lands in idle (after an abort, say) is armed again one cycle later
    // single arm strobe shared by all channels
    assign arm_all = i_cmd_arm | i_continuous_rearm;

    // the two bus trigger paths are merged here, so a channel cannot tell
    // them apart; both arriving in one cycle make a single event
    // both bus trigger commands count as one source
    assign bus_evt = i_bus_trg_cmd | i_bus_trg_ws;

    // previous levels of the backplane and spare lines
    // only the power-on reset clears this history: the reset command keeps
    // it, so a line that is already high when that command lands is not
    // taken for a fresh transition on the following cycle
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            line_prev_r <= '0;
            aux_prev_r <= 1'b0;
        end else begin
            line_prev_r <= {i_ttl_trg, i_ecl_trg};
            aux_prev_r <= i_aux_trg;
        end
    end

    // a transition is a rising edge of the line
    // lines idle low, so a history cleared to zero shows no edge after reset;
    // a line held high counts once, however long it stays up
    assign line_rise = {i_ttl_trg, i_ecl_trg} & ~line_prev_r;
    assign aux_rise = i_aux_trg & ~aux_prev_r;

    // bit 0 is the bus trigger, then the two ECL lines, the eight TTL lines
    // and the spare line on top, so a source code indexes its own event
    // event vector indexed by source code
    assign evt_vec = {aux_rise, line_rise, bus_evt};

    // legality of written values
    // a refused write leaves the old setting in place, so a bad code or a
    // zero count never half-programs a channel; readback shows the old value
    assign cfg_src_ok = (i_cfg_data[`TSQ_SRC_W-1:0] <= `TSQ_SRC_LAST) &&
                        (i_cfg_data[CW-1:`TSQ_SRC_W] == '0);
    assign cfg_cnt_ok = (i_cfg_data >= `TSQ_COUNT_MIN);

    // each channel owns its source and both counts; the channels share only
    // the command strobes and the event vector, so they run independently
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_chan
            logic src_evt;

            // the reset command restores the settings as well as idling the
            // channel, while an abort leaves them alone
            // per-channel source, bus after reset
            always_ff @(posedge i_mclk) begin
                if (i_srst || i_cmd_reset) begin
                    src_r[c] <= `TSQ_SRC_BUS;
                end else if (i_cfg_wr && cfg_sel[c] && i_cfg_field == `TSQ_CFG_SRC &&
                             cfg_src_ok) begin
                    src_r[c] <= i_cfg_data[`TSQ_SRC_W-1:0];
                end
            end

            // event count setting, out of range writes dropped
            always_ff @(posedge i_mclk) begin
                if (i_srst || i_cmd_reset) begin
                    event_count_setting_r[c] <= `TSQ_COUNT_DEF;
                end else if (i_cfg_wr && cfg_sel[c] && i_cfg_field == `TSQ_CFG_ECNT &&
                             cfg_cnt_ok) begin
                    event_count_setting_r[c] <= i_cfg_data;
                end
            end

            always_ff @(posedge i_mclk) begin
                if (i_srst || i_cmd_reset) begin
                    tcount_r[c] <= `TSQ_COUNT_DEF;
                end else if (i_cfg_wr && cfg_sel[c] && i_cfg_field == `TSQ_CFG_TCNT &&
                             cfg_cnt_ok) begin
                    tcount_r[c] <= i_cfg_data;
                end
            end

            // codes above the last source are refused on write, so the index stays in range
            // select the channel's source event
            assign src_evt = evt_vec[src_r[c]];

            // the channel raises its own ignore flag, since only it knows
            // whether it was armed when the force or simulate arrived
            // identical channel instances
            tsq_chan #(
                .CW(CW)
            ) u_chan (
                .i_mclk(i_mclk),
                .i_srst(i_srst),
                .i_idle_all(idle_all),
                .i_arm_all(arm_all),
                .i_rearm(i_continuous_rearm),
                .i_src_evt(src_evt),
                .i_sim_evt(i_sim_trg & trg_sel[c]),
                .i_force(i_force_trg & trg_sel[c]),
                .i_event_count_setting(event_count_setting_r[c]),
                .i_tcount(tcount_r[c]),
                .o_state(o_chan_state[2*c +: 2]),
                .o_action(o_action_strb[c]),
                .o_ignored(o_trg_ignored[c])
            );
        end
    endgenerate

    // readback follows i_rd_chan one cycle late; only power-on resets it,
    // and it shows the settings restored by the reset command a cycle after
    // readback of the chosen channel's source
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rd_src <= `TSQ_SRC_BUS;
        end else begin
            o_rd_src <= src_r[i_rd_chan];
        end
    end

    // readback of the chosen channel's event count setting
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rd_event_count_setting <= `TSQ_COUNT_DEF;
        end else begin
            o_rd_event_count_setting <= event_count_setting_r[i_rd_chan];
        end
    end

    // readback of the chosen channel's trigger count setting
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rd_tcount <= `TSQ_COUNT_DEF;
        end else begin
            o_rd_tcount <= tcount_r[i_rd_chan];
        end
    end
endmodule

// ---- tb/tsq_line_model.sv ----
// far-side model of the backplane trigger lines
`timescale 1ns/10ps
module tsq_line_model (
    input wire logic i_mclk,
    input wire logic i_go,
    input wire logic [3:0] i_sel,
    output logic [1:0] o_ecl,
    output logic [7:0] o_ttl,
    output logic o_aux
);
    logic [1:0] hold_r = 2'h0;
    logic [11:0] lines;
    // a fired line stays high two cycles, then falls back to its low idle level
    always_ff @(posedge i_mclk) begin
        if (i_go)
            hold_r <= 2'h2;
        else if (hold_r != 2'h0)
            hold_r <= hold_r - 2'h1;
    end
    assign lines = (hold_r != 2'h0) ? (12'h001 << i_sel) : 12'h000;
    assign o_ecl = lines[2:1];
    assign o_ttl = lines[10:3];
    assign o_aux = lines[11];
endmodule

// ---- tb/tsq_top_properties.sv ----
// port-level checker for the trigger sequencer
`timescale 1ns/10ps
module tsq_top_properties #(
    parameter int NCH = 4
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_cmd_reset,
    input wire logic i_cmd_abort,
    input wire logic i_cmd_arm,
    input wire logic i_continuous_rearm,
    input wire logic i_force_trg,
    input wire logic i_trg_chan_vld,
    input wire logic [2*NCH-1:0] o_chan_state,
    input wire logic [NCH-1:0] o_action_strb,
    input wire logic [NCH-1:0] o_trg_ignored
);
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    // arm while every channel idles
    sequence s_group_arm;
        o_chan_state == '0 ##0 (i_cmd_arm && !i_cmd_abort && !i_cmd_reset);
    endsequence
    // unselected force reaching an armed first channel
    sequence s_force_ch0;
        o_chan_state[1:0] == 2'b01 ##0
            (i_force_trg && !i_trg_chan_vld && !i_cmd_abort && !i_cmd_reset);
    endsequence
    a_abort_idle: assert property ((i_cmd_abort || i_cmd_reset) |=> o_chan_state == '0)
        else $error("abort or reset left a channel active");
    a_arm_group: assert property (s_group_arm |=> o_chan_state == {NCH{2'b01}})
        else $error("arm did not arm all channels");
    a_force_trig: assert property (s_force_ch0 |=> o_chan_state[1:0] == 2'b11)
        else $error("forced trigger missed");
    a_strobe_match: assert property (
        o_action_strb == {&o_chan_state[7:6], &o_chan_state[5:4],
            &o_chan_state[3:2], &o_chan_state[1:0]})
        else $error("action strobe differs from triggered state");
    a_trig_once: assert property (
        o_chan_state[1:0] == 2'b11 |=> o_chan_state[1:0] inside {2'b00, 2'b01})
        else $error("triggered state held");
    a_rearm_armed: assert property (
        (o_chan_state[1:0] == 2'b11 && i_continuous_rearm && !i_cmd_abort && !i_cmd_reset)
        |=> o_chan_state[1:0] == 2'b01)
        else $error("continuous mode did not re-arm");
    a_idle_holds: assert property (
        (o_chan_state[1:0] == 2'b00 && !i_cmd_arm && !i_continuous_rearm)
        |=> o_chan_state[1:0] == 2'b00)
        else $error("idle channel left without arm");
    a_ignore_flag: assert property (
        (o_chan_state[1:0] != 2'b01 && i_force_trg && !i_trg_chan_vld)
        |=> o_trg_ignored[0])
        else $error("ignored force not flagged");
endmodule
bind tsq_top tsq_top_properties #(.NCH(NCH)) u_props (.i_mclk(i_mclk), .i_srst(i_srst),
    .i_cmd_reset(i_cmd_reset), .i_cmd_abort(i_cmd_abort), .i_cmd_arm(i_cmd_arm),
    .i_continuous_rearm(i_continuous_rearm), .i_force_trg(i_force_trg),
    .i_trg_chan_vld(i_trg_chan_vld), .o_chan_state(o_chan_state),
    .o_action_strb(o_action_strb), .o_trg_ignored(o_trg_ignored));

// ---- tb/tsq_top_bench.sv ----
// self-checking bench for the trigger sequencer
`timescale 1ns/10ps
`include "tsq_defines.svh"
module tsq_top_bench;
    logic i_mclk, i_srst, i_cmd_reset, i_cmd_abort, i_cmd_arm, i_continuous_rearm, go;
    logic i_bus_trg_cmd, i_bus_trg_ws, i_aux_trg, i_cfg_wr, i_cfg_chan_vld, i_force_trg;
    logic i_sim_trg, i_trg_chan_vld;
    logic [1:0] i_ecl_trg, i_cfg_chan, i_cfg_field, i_trg_chan, i_rd_chan;
    logic [7:0] i_ttl_trg, o_chan_state;
    logic [14:0] i_cfg_data, o_rd_event_count_setting, o_rd_tcount;
    logic [3:0] o_action_strb, o_trg_ignored, o_rd_src, sel, want;
    logic [3:0] notes[$];
    int n_fail, compares, cyc, n;
    tsq_top u_dut (.i_mclk(i_mclk), .i_srst(i_srst), .i_cmd_reset(i_cmd_reset),
        .i_cmd_abort(i_cmd_abort), .i_cmd_arm(i_cmd_arm), .i_continuous_rearm(i_continuous_rearm),
        .i_bus_trg_cmd(i_bus_trg_cmd), .i_bus_trg_ws(i_bus_trg_ws), .i_ecl_trg(i_ecl_trg),
        .i_ttl_trg(i_ttl_trg), .i_aux_trg(i_aux_trg), .i_cfg_wr(i_cfg_wr),
        .i_cfg_chan_vld(i_cfg_chan_vld), .i_cfg_chan(i_cfg_chan), .i_cfg_field(i_cfg_field),
        .i_cfg_data(i_cfg_data), .i_force_trg(i_force_trg), .i_sim_trg(i_sim_trg),
        .i_trg_chan_vld(i_trg_chan_vld), .i_trg_chan(i_trg_chan), .i_rd_chan(i_rd_chan),
        .o_chan_state(o_chan_state), .o_action_strb(o_action_strb),
        .o_trg_ignored(o_trg_ignored), .o_rd_src(o_rd_src), .o_rd_event_count_setting(o_rd_event_count_setting),
        .o_rd_tcount(o_rd_tcount));
    tsq_line_model u_lines (.i_mclk(i_mclk), .i_go(go), .i_sel(sel), .o_ecl(i_ecl_trg),
        .o_ttl(i_ttl_trg), .o_aux(i_aux_trg));
    task automatic tick(input int k = 1);
        repeat (k) @(posedge i_mclk);
    endtask
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic st(input logic [7:0] e);
        #1;
        chk({8'h00, o_chan_state}, {8'h00, e});
        @(posedge i_mclk);
    endtask
    // channel zero always goes without a selector, to a bogus channel number
    task automatic cfg(input logic [1:0] ch, input logic [1:0] fld, input logic [14:0] d);
        i_cfg_wr <= 1'b1;
        i_cfg_chan_vld <= (ch != 2'h0);
        i_cfg_chan <= (ch == 2'h0) ? 2'h3 : ch;
        i_cfg_field <= fld;
        i_cfg_data <= d;
        tick;
        i_cfg_wr <= 1'b0;
        tick;
    endtask
    task automatic arm;
        i_cmd_arm <= 1'b1;
        tick;
        i_cmd_arm <= 1'b0;
        tick;
    endtask
    // code 12 stands for the word serial bus trigger
    task automatic fire(input logic [3:0] s);
        if (s == 4'h0)
            i_bus_trg_cmd <= 1'b1;
        else if (s == 4'hC)
            i_bus_trg_ws <= 1'b1;
        else begin
            sel <= s;
            go <= 1'b1;
        end
        tick;
        {i_bus_trg_cmd, i_bus_trg_ws, go} <= 3'h0;
        tick(6);
    endtask
    task automatic test_done;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    // clock
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end
    // each action strobe is matched to the oldest note, mid-cycle where it is settled
    always @(negedge i_mclk) begin
        if (i_srst === 1'b0 && o_action_strb !== 4'h0) begin
            want = notes.size() ? notes.pop_front() : 4'h0;
            chk({12'h000, o_action_strb}, {12'h000, want});
        end
    end
    // cycle ceiling: a hang counts as a mismatch and ends the run
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 3000) begin
            n_fail++;
            test_done;
        end
    end
    // main sequence
    initial begin
        {i_cmd_reset, i_cmd_abort, i_cmd_arm, i_continuous_rearm, i_bus_trg_cmd} = '0;
        {i_bus_trg_ws, i_cfg_wr, i_cfg_chan_vld, i_force_trg, i_sim_trg, i_trg_chan_vld} = '0;
        {i_cfg_chan, i_cfg_field, i_trg_chan, i_rd_chan, i_cfg_data, sel, go} = '0;
        i_srst = 1'b1;
        n = $urandom(32'h55AC);
        tick(6);
        i_srst <= 1'b0;
        tick;
        for (int c = 0; c < 4; c++) begin
            i_rd_chan <= c[1:0];
            tick(2);
            #1;
            chk({12'h000, o_rd_src}, 16'h0000);
            chk({1'b0, o_rd_event_count_setting}, 16'h0001);
            chk({1'b0, o_rd_tcount}, 16'h0001);
        end
        for (int s = 0; s < 13; s++) begin
            for (int c = 0; c < 4; c++)
                cfg(c[1:0], `TSQ_CFG_SRC, (s == 12) ? 15'h0000 : 15'(s));
            arm;
            notes.push_back(4'hF);
            fire(s[3:0]);
            st(8'h00);
        end
        n = $urandom_range(5, 2);
        cfg(2'h1, `TSQ_CFG_ECNT, 15'(n));
        arm;
        notes.push_back(4'hD);
        fire(4'h0);
        repeat (n - 2) fire(4'hC);
        st(8'h04);
        notes.push_back(4'h2);
        {i_sim_trg, i_trg_chan_vld, i_trg_chan} <= 4'hD;
        tick;
        {i_sim_trg, i_trg_chan_vld} <= 2'h0;
        tick(3);
        st(8'h00);
        i_force_trg <= 1'b1;
        tick;
        i_force_trg <= 1'b0;
        #1;
        chk({12'h000, o_trg_ignored}, 16'h0001);
        tick;
        cfg(2'h0, `TSQ_CFG_TCNT, 15'h0002);
        arm;
        repeat (2) begin
            notes.push_back(4'h1);
            i_force_trg <= 1'b1;
            tick;
            i_force_trg <= 1'b0;
            tick(2);
        end
        st(8'h54);
        i_cmd_abort <= 1'b1;
        tick;
        i_cmd_abort <= 1'b0;
        st(8'h00);
        i_continuous_rearm <= 1'b1;
        tick(2);
        // channel one still needs more than one event under its larger count
        notes.push_back(4'hD);
        fire(4'h0);
        st(8'h55);
        // a zero event count is refused, so channel one keeps its setting
        cfg(2'h1, `TSQ_CFG_ECNT, 15'h0000);
        i_rd_chan <= 2'h1;
        tick(2);
        #1;
        chk({1'b0, o_rd_event_count_setting}, 16'(n));
        {i_cmd_reset, i_continuous_rearm} <= 2'h2;
        i_rd_chan <= 2'h0;
        tick;
        i_cmd_reset <= 1'b0;
        st(8'h00);
        tick(2);
        #1;
        chk({1'b0, o_rd_tcount}, 16'h0001);
        chk(16'(notes.size()), 16'h0000);
        test_done;
    end
endmodule
